// >>> rtl/keyboard_serial_interface.sv
/*
  Keyboard two-wire link: shift frame, control/status port, receive and transmit.
  Assumes a CPU I/O strobe pair on the system clock and a keyboard driving the clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "kbd_link_consts.svh"
module keyboard_serial_interface
  import kbd_link_pkg::*;
#(
  parameter int FRAME_BITS = `KBD_FRAME_BITS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // CPU I/O port
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  // External status bits shown on reads of bits 3..2
  input wire logic [1:0] vdu_ptr_hi_in,
  // Keyboard lines, open drain
  input wire logic kbd_clock_line_in,
  output logic kbd_clock_line_out,
  output logic kbd_clock_line_oe_n_out,
  input wire logic kbd_data_line_in,
  output logic kbd_data_line_out,
  output logic kbd_data_line_oe_n_out,
  // Interrupt towards system status
  output logic keyboard_irq_out
);
  logic [FRAME_BITS-1:0] frame, next_frame;
  logic busy, next_busy;
  logic irq, next_irq;
  logic force_clk, next_force_clk;
  logic tx_mode, next_tx_mode;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] rdata, next_rdata;
  link_state_t state, next_state;
  logic [1:0] line_raw;
  logic [1:0] line_sync;
  logic clk_s2, clk_s3, next_clk_s3, dat_s2;
  logic clk_fall;
  logic data_wr, data_rd, ctrl_wr, ctrl_rd, iface_reset;

  // Bit 0 clock, bit 1 data; both pins are asynchronous to the system clock
  assign line_raw = {kbd_data_line_in, kbd_clock_line_in};

  // Two-flop synchroniser per line; idle level high so reset gives no false edge [R21] [R8]
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      logic s1, s2, next_s1, next_s2;
      always_comb begin
        next_s1 = line_raw[i];
        next_s2 = s1;
      end
      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
        end else begin
          s1 <= next_s1;
          s2 <= next_s2;
        end
      end
      assign line_sync[i] = s2;
    end
  endgenerate
  assign clk_s2 = line_sync[0];
  assign dat_s2 = line_sync[1];

  // Third stage on the clock only, read solely by the edge finder [R21]
  always_comb begin
    next_clk_s3 = clk_s2;
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_s3 <= 1'b1;
    end else begin
      clk_s3 <= next_clk_s3;
    end
  end
  assign clk_fall = clk_s3 & ~clk_s2; // [R21]

  assign data_wr = io_wr_in && io_addr_in == `KBD_DATA_ADDR;
  assign data_rd = io_rd_in && io_addr_in == `KBD_DATA_ADDR;
  assign ctrl_wr = io_wr_in && io_addr_in == `KBD_CTRL_ADDR;
  assign ctrl_rd = io_rd_in && io_addr_in == `KBD_CTRL_ADDR;
  // Read of the data port also resets, so sample data before clearing
  assign iface_reset = data_rd || (ctrl_wr && io_wdata_in[`KBD_BIT_RESET]); // [R3]

  always_comb begin
    next_frame = frame;
    next_busy = busy;
    next_irq = irq;
    next_force_clk = force_clk;
    next_tx_mode = tx_mode;
    next_bit_cnt = bit_cnt;
    next_state = state;
    next_rdata = rdata;
    // Shift on each keyboard clock fall until the frame is done; no parity check is made [R21] [R11]
    if (clk_fall && state != LINK_DONE) begin
      next_busy = 1'b1; // [R9]
      next_state = LINK_BUSY;
      next_frame = {dat_s2, frame[FRAME_BITS-1:1]};
      if (tx_mode) begin
        // Transmit shifts in ones behind the outgoing bits [R17]
        next_frame = {1'b1, frame[FRAME_BITS-1:1]};
      end
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'(FRAME_BITS - 1)) begin
        next_irq = 1'b1; // [R4] [R17]
        next_state = LINK_DONE;
      end
    end
    if (iface_reset) begin
      next_busy = 1'b0; // [R3]
      next_irq = 1'b0;
      next_bit_cnt = 4'h0;
      next_state = LINK_IDLE;
    end
    if (data_wr) begin
      // Start 0, data, parity 0, stop 1 [R2] [R1]
      next_frame = {1'b1, 1'b0, io_wdata_in, 1'b0};
    end
    if (ctrl_wr) begin
      next_force_clk = io_wdata_in[`KBD_BIT_FORCE]; // [R7] [R13]
      next_tx_mode = io_wdata_in[`KBD_BIT_TXMODE]; // [R7] [R14]
      if (io_wdata_in[`KBD_BIT_PARITY]) begin
        next_frame[`KBD_FP_PARITY] = 1'b1; // [R6]
      end
    end
    if (data_rd) begin
      next_rdata = frame[8:1]; // [R1]
    end else if (ctrl_rd) begin
      // [R5]
      next_rdata = {frame[`KBD_FP_PARITY], frame[`KBD_FP_STOP], frame[`KBD_FP_START],
                    busy, vdu_ptr_hi_in, force_clk, tx_mode};
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame <= `KBD_FRAME_RESET;
      busy <= 1'b0;
      irq <= 1'b0;
      force_clk <= 1'b0;
      tx_mode <= 1'b0;
      bit_cnt <= 4'h0;
      state <= LINK_IDLE;
      rdata <= 8'h00;
    end else begin
      frame <= next_frame;
      busy <= next_busy;
      irq <= next_irq;
      force_clk <= next_force_clk;
      tx_mode <= next_tx_mode;
      bit_cnt <= next_bit_cnt;
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  // Read data is registered: valid the cycle after the read strobe
  assign io_rdata_out = rdata;
  // Lines idle high after reset; clock low only when forced, data low only in transmit mode on a zero bit [R8] [R13] [R14]
  assign kbd_clock_line_out = 1'b0;
  assign kbd_clock_line_oe_n_out = ~force_clk;
  assign kbd_data_line_out = 1'b0;
  assign kbd_data_line_oe_n_out = ~(tx_mode & ~frame[0]);
  // Source bit for the system status register [R20]
  assign keyboard_irq_out = irq;

  sequence s_last_fall;
    clk_fall && state != LINK_DONE && bit_cnt == 4'(FRAME_BITS - 1) && !iface_reset;
  endsequence
  chk_irq_on_frame: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
    s_last_fall |=> keyboard_irq_out) else $error("irq not raised at frame end");
  chk_irq_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
    keyboard_irq_out && !iface_reset |=> keyboard_irq_out) else $error("irq dropped");
  chk_read_clears: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
    data_rd |=> !busy && !keyboard_irq_out && bit_cnt == 4'h0) else $error("read no clear");
  chk_busy_on_fall: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
    clk_fall && state == LINK_IDLE && !iface_reset |=> busy) else $error("busy not set");
  chk_busy_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
    busy && !iface_reset |=> busy) else $error("busy dropped");
  chk_write_frame: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
    data_wr && !ctrl_wr |=> frame[0] == 1'b0 && frame[9] == 1'b0 && frame[10]
      && frame[8:1] == $past(io_wdata_in)) else $error("frame preset wrong");
  chk_parity_set: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R6]
    ctrl_wr && io_wdata_in[7] && !data_wr |=> frame[9]) else $error("parity not set");
  chk_force_clock: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R13]
    ctrl_wr && io_wdata_in[`KBD_BIT_FORCE] |=> !kbd_clock_line_oe_n_out) else $error("clk not low");
  chk_tx_drive: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R14]
    ctrl_wr && io_wdata_in[`KBD_BIT_TXMODE] && !frame[`KBD_FP_START] && !clk_fall
      |=> !kbd_data_line_oe_n_out) else $error("start not driven");
  chk_status_read: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
    ctrl_rd |=> io_rdata_out[4] == $past(busy) && io_rdata_out[1:0]
      == {$past(force_clk), $past(tx_mode)}) else $error("status read wrong");

  // Steps of one frame bit and of the control writes
  sequence s_rx_fall;
    clk_fall && state != LINK_DONE && !tx_mode && !iface_reset && !data_wr && !ctrl_wr;
  endsequence
  sequence s_tx_fall;
    clk_fall && state != LINK_DONE && tx_mode && !iface_reset && !data_wr && !ctrl_wr;
  endsequence
  sequence s_late_fall;
    clk_fall && state == LINK_DONE && !iface_reset && !data_wr && !ctrl_wr;
  endsequence
  sequence s_ctrl_reset;
    ctrl_wr && io_wdata_in[`KBD_BIT_RESET];
  endsequence
  sequence s_force_off;
    ctrl_wr && !io_wdata_in[`KBD_BIT_FORCE];
  endsequence

  // Frame shifting, one bit per synchronised fall
  chk_rx_shift: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R21]
    s_rx_fall |=> frame == {$past(dat_s2), $past(frame[FRAME_BITS-1:1])})
    else $error("receive shift wrong");
  chk_tx_shift: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R17]
    s_tx_fall |=> frame == {1'b1, $past(frame[FRAME_BITS-1:1])})
    else $error("transmit shift wrong");
  chk_late_fall: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R21]
    s_late_fall |=> $stable(frame) && $stable(bit_cnt))
    else $error("fall after frame end");
  chk_count_step: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R21]
    clk_fall && state != LINK_DONE && !iface_reset |=> bit_cnt == $past(bit_cnt) + 4'h1)
    else $error("bit count step wrong");
  chk_count_range: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R1]
    bit_cnt <= 4'(FRAME_BITS))
    else $error("bit count past frame");
  chk_state_onehot: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R21]
    $onehot(state))
    else $error("link state not one-hot");
  chk_rx_start: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
    clk_fall && state == LINK_IDLE && !iface_reset |=> state == LINK_BUSY)
    else $error("frame start not seen");

  // Interrupt and busy move only for a cause; a lost edge would hang the CPU
  chk_irq_cause: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
    $rose(keyboard_irq_out) |-> $past(clk_fall) && $past(bit_cnt) == 4'(FRAME_BITS - 1))
    else $error("irq without frame end");
  chk_irq_done: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
    keyboard_irq_out |-> state == LINK_DONE)
    else $error("irq outside frame end");
  chk_irq_busy: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
    keyboard_irq_out |-> busy)
    else $error("irq without busy");
  chk_done_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
    state == LINK_DONE && !iface_reset |=> state == LINK_DONE)
    else $error("done dropped");
  chk_busy_cause: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R9]
    $rose(busy) |-> $past(clk_fall))
    else $error("busy without clock fall");
  chk_ctrl_reset: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
    s_ctrl_reset |=> !busy && !keyboard_irq_out && state == LINK_IDLE)
    else $error("control reset no clear");
  chk_count_clear: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
    iface_reset |=> bit_cnt == 4'h0)
    else $error("bit count not cleared");
  chk_read_keeps: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
    data_rd && !data_wr && !ctrl_wr && !clk_fall |=> $stable(frame))
    else $error("data read changed frame");

  // Register port read data
  chk_data_read: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R1]
    data_rd |=> io_rdata_out == $past(frame[8:1]))
    else $error("data read wrong");
  chk_status_frame: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
    ctrl_rd && !data_rd |=> io_rdata_out[7:5] == {$past(frame[`KBD_FP_PARITY]),
      $past(frame[`KBD_FP_STOP]), $past(frame[`KBD_FP_START])})
    else $error("frame bits wrong");
  chk_status_vdu: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
    ctrl_rd && !data_rd |=> io_rdata_out[3:2] == $past(vdu_ptr_hi_in))
    else $error("pointer bits wrong");
  chk_rdata_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
    !data_rd && !ctrl_rd |=> $stable(io_rdata_out))
    else $error("read data moved");

  // Control bits stored as written; force holds the clock low
  chk_ctrl_store: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
    ctrl_wr |=> force_clk == $past(io_wdata_in[`KBD_BIT_FORCE])
      && tx_mode == $past(io_wdata_in[`KBD_BIT_TXMODE]))
    else $error("control not stored");
  chk_ctrl_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
    !ctrl_wr |=> $stable(force_clk) && $stable(tx_mode))
    else $error("control bits moved");
  chk_force_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R13]
    !kbd_clock_line_oe_n_out && !ctrl_wr |=> !kbd_clock_line_oe_n_out)
    else $error("forced clock released");
  chk_force_off: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R13]
    s_force_off |=> kbd_clock_line_oe_n_out)
    else $error("clock still forced");
  chk_tx_leave: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R18]
    ctrl_wr && !io_wdata_in[`KBD_BIT_TXMODE] |=> kbd_data_line_oe_n_out)
    else $error("data still driven");
  chk_parity_clear: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R6]
    data_wr |=> !frame[`KBD_FP_PARITY])
    else $error("parity not cleared");
endmodule
`default_nettype wire

// >>> rtl/kbd_link_consts.svh
/*
  Register offsets, field positions, reset values and timing for the keyboard link block.
  Assumes inclusion by bare name from the package and the design module.
*/
// Notes on behaviour
// R1: Eleven-bit frame, data byte at data port
// R2: Data write loads byte, parity0 start0 stop1
// R3: Data read clears irq, busy, rearms reception
// R4: Interrupt on complete received byte, held
// R5: Status read shows parity, stop, start, busy
// R6: Control bit7 sets parity; data write clears
// R7: Force-clock and transmit bits read back
// R8: Clock and data lines idle high at reset
// R9: Busy set when keyboard starts clocking frame
// R10: Keyboard sends only when both lines idle
// R11: No parity check; CPU checks odd parity
// R12: CPU checks busy clear before transmit/holdoff
// R13: Force-clock bit drives keyboard clock low
// R14: Transmit mode puts frame on data line
// R15: CPU waits 60us after forcing clock low
// R16: CPU releases clock writing transmit only
// R17: Keyboard clocks frame out, then interrupt
// R18: CPU resets interface after transmit interrupt
// R19: Holdoff by forced clock, then reset interface
// R20: Interrupt reported as system status source
// R21: Synchronise lines, shift on clock falls
`ifndef KBD_LINK_CONSTS_SVH
`define KBD_LINK_CONSTS_SVH
`define KBD_DATA_ADDR 8'hF4
`define KBD_CTRL_ADDR 8'hF5
`define KBD_FRAME_BITS 11
`define KBD_FRAME_RESET 11'h7FF
`define KBD_BIT_PARITY 7
`define KBD_BIT_STOP 6
`define KBD_BIT_START 5
`define KBD_BIT_BUSY 4
`define KBD_BIT_RESET 2
`define KBD_BIT_FORCE 1
`define KBD_BIT_TXMODE 0
`define KBD_FP_PARITY 9
`define KBD_FP_STOP 10
`define KBD_FP_START 0
`define KBD_FORCE_MIN_US 60
`define KBD_FORCE_MIN_CYC ((`KBD_FORCE_MIN_US * 100 + 0) / 1)
`endif

// >>> rtl/kbd_link_pkg.sv
/*
  Types for the keyboard link block.
  Assumes the constants header sits beside it.
*/
`include "kbd_link_consts.svh"
package kbd_link_pkg;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_BUSY = 3'b010,
    LINK_DONE = 3'b100
  } link_state_t;
endpackage

// >>> tb/kbd_model.sv
/*
  Keyboard model: pulls link clock and data open drain, sends and takes frames.
  Assumes the bench resolves wire levels with pull-ups and the device's pulls.
*/
`timescale 1ns/1ns
`default_nettype none
module kbd_model (
  // Resolved wire levels
  input wire logic clk_w_in,
  input wire logic dat_w_in,
  // Pulls, 1 = released
  output logic kb_clk_out,
  output logic kb_dat_out
);
  initial begin
    kb_clk_out = 1'b1;
    kb_dat_out = 1'b1;
  end
  // Clock stands high between frames
  task automatic send(input logic [7:0] b, input logic par);
    logic [10:0] f;
    int n;
    f = {1'b1, par, b, 1'b0};
    n = 0;
    while (!(clk_w_in && dat_w_in) && n < 1000) begin
      #125;
      n++;
    end
    for (int i = 0; i < 11; i++) begin
      kb_dat_out = f[i];
      #31 kb_clk_out = 1'b0;
      #62 kb_clk_out = 1'b1;
      #32;
    end
    kb_dat_out = 1'b1;
  endtask
  // Samples while clock high, before each fall
  task automatic take(output logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      #31 f[i] = dat_w_in;
      kb_clk_out = 1'b0;
      #62 kb_clk_out = 1'b1;
      #32;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/keyboard_serial_interface_bench.sv
/*
  Bench: CPU port tasks, receive and transmit scenarios against the keyboard model.
  Assumes pull-ups on both link wires.
*/
`timescale 1ns/1ns
`default_nettype none
module keyboard_serial_interface_bench;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, irq, c_oe_n, d_oe_n, kc, kd, c_out, d_out;
  logic [1:0] vdu = 2'b10;
  logic [10:0] f;
  wire logic clk_w = (c_oe_n | c_out) & kc;
  wire logic dat_w = (d_oe_n | d_out) & kd;
  int err_count = 0, compares = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  keyboard_serial_interface uut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd),
    .io_rdata_out(rdata), .vdu_ptr_hi_in(vdu), .kbd_clock_line_in(clk_w),
    .kbd_clock_line_out(c_out), .kbd_clock_line_oe_n_out(c_oe_n), .kbd_data_line_in(dat_w),
    .kbd_data_line_out(d_out), .kbd_data_line_oe_n_out(d_oe_n), .keyboard_irq_out(irq));
  kbd_model kbd (.clk_w_in(clk_w), .dat_w_in(dat_w), .kb_clk_out(kc), .kb_dat_out(kd));
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  // Read data settles on the same edge that takes the strobe
  task automatic io_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge sys_clk_in);
      n++;
      if (n > 3000) begin
        err_count++;
        close_out();
      end
    end
  endtask
  task automatic t_reset();
    chk({c_oe_n, d_oe_n, irq}, 3'b110);
    io_rd(8'hF5, 8'hE8);
    io_rd(8'hF6, 8'hE8);
    $display("reset test done");
  endtask
  // Second frame carries wrong parity and must still be taken
  task automatic t_receive(input logic [7:0] b, input logic p, input logic [7:0] st);
    kbd.send(b, p);
    wait_irq();
    chk(irq, 1'b1);
    io_rd(8'hF5, st);
    io_rd(8'hF4, b);
    chk(irq, 1'b0);
    io_rd(8'hF5, st & 8'hEF);
    $display("receive test done");
  endtask
  task automatic t_transmit();
    io_rd(8'hF5, 8'h48);
    io_wr(8'hF5, 8'h02);
    #1 chk({c_oe_n, d_oe_n}, 2'b01);
    // Forced fall needs three cycles to reach the shifter; load data after it
    repeat (4) @(posedge sys_clk_in);
    io_wr(8'hF4, 8'h5A);
    io_rd(8'hF5, 8'h5A);
    repeat (6000) @(posedge sys_clk_in);
    io_wr(8'hF5, 8'h87);
    io_rd(8'hF5, 8'hCB);
    chk({c_oe_n, d_oe_n}, 2'b00);
    io_wr(8'hF5, 8'h01);
    #1 chk(c_oe_n, 1'b1);
    kbd.take(f);
    chk(f, 11'h6B4);
    wait_irq();
    io_rd(8'hF5, 8'hF9);
    io_wr(8'hF5, 8'h04);
    #1 chk({irq, d_oe_n}, 2'b01);
    $display("transmit test done");
  endtask
  task automatic t_holdoff();
    io_wr(8'hF5, 8'h02);
    repeat (4) @(posedge sys_clk_in);
    io_rd(8'hF5, 8'hFA);
    chk(irq, 1'b0);
    io_wr(8'hF5, 8'h00);
    io_wr(8'hF5, 8'h04);
    io_rd(8'hF5, 8'hE8);
    $display("holdoff test done");
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_receive(8'hA5, 1'b1, 8'hD8);
    t_receive(8'h3C, 1'b0, 8'h58);
    t_transmit();
    t_holdoff();
    close_out();
  end
endmodule
`default_nettype wire
